/* File: inc/lsf_regs.vh */
// Register map, field layout and timing constants for the sink fade block
`ifndef LSF_REGS_VH
`define LSF_REGS_VH
`define LSF_ADDR_FADE 8'h1E
`define LSF_ADDR_LED1 8'h1F
`define LSF_ADDR_LED2 8'h20
`define LSF_FADE_RESET 8'h00
`define LSF_CUR_RESET 7'h00
`define LSF_CODE_FULL 7'h7F
`define LSF_CODE_ZERO 7'h00
`define LSF_RSVD_ZERO 1'b0
`define LSF_FADE_OFF 4'h0
`define LSF_FADE_DN_HI 7
`define LSF_FADE_DN_LO 4
`define LSF_FADE_UP_HI 3
`define LSF_FADE_UP_LO 0
`define LSF_CUR_HI 6
`define LSF_CUR_LO 0
`define LSF_READ_IDLE 8'h00
`define LSF_CODE_PAD 4'h0
`define LSF_PROD_PAD 56'h0
`define LSF_TICK_ZERO 32'h0
`define LSF_TICK_ONE 32'h1
`define LSF_CODE_STEP 7'h01
`define LSF_CODE_LINEAR_MAX 4'hA
// Duration units of 0.1 s; 0.30 s per code below eleven, then half-second steps
`define LSF_TENTH_PER_CODE 8'h03
`define LSF_TENTH_AT_CODE10 8'h1E
`define LSF_TENTH_PER_HALF 8'h05
// 0.1 s at 10 MHz is 1000000 cycles; 127 steps per full ramp
`define LSF_CLK_HZ 32'd10000000
`define LSF_TENTHS_PER_SEC 32'd10
`define LSF_STEPS 32'd127
`endif

/* File: design/lsf_sink_fade.v */
// Sink fade timing and two per-LED current code channels
`include "lsf_regs.vh"

// ----------------------------------------
// Step timer for one channel
// ----------------------------------------
module lsf_ramp #(
  parameter TENTH_CYCLES = 1000000
) (
  ref_clk,
  resetn,
  target,
  on_req,
  dn_code,
  up_code,
  applied
);
  input wire ref_clk;
  input wire resetn;
  input wire [6:0] target;
  input wire on_req;
  input wire [3:0] dn_code;
  input wire [3:0] up_code;
  output reg [6:0] applied;

  // ----------------------------------------
  // Ramp state
  // ----------------------------------------
  reg [31:0] tick;
  reg [31:0] next_tick;
  reg [6:0] next_applied;
  reg [31:0] limit;
  reg [7:0] tenths;
  reg [7:0] over_ten;
  reg [3:0] code;
  wire [6:0] goal;
  wire going_up;
  wire at_goal;
  wire step_due;
  wire [63:0] prod;

  // ----------------------------------------
  // Direction and goal
  // ----------------------------------------
  // Off request ramps toward zero, not the register
  assign goal = on_req ? target : `LSF_CODE_ZERO;
  assign going_up = goal > applied;
  assign at_goal = goal == applied;

  // ----------------------------------------
  // Duration in tenths of a second
  // ----------------------------------------
  always @* begin
    over_ten = {`LSF_CODE_PAD, code} - {`LSF_CODE_PAD, `LSF_CODE_LINEAR_MAX};
    // Rising uses fade-in code, falling fade-out code
    code = going_up ? up_code : dn_code;
    over_ten = {`LSF_CODE_PAD, code} - {`LSF_CODE_PAD, `LSF_CODE_LINEAR_MAX};
    if (code <= `LSF_CODE_LINEAR_MAX) begin
      tenths = {`LSF_CODE_PAD, code} * `LSF_TENTH_PER_CODE;
    end else begin
      tenths = `LSF_TENTH_AT_CODE10 + over_ten * `LSF_TENTH_PER_HALF;
    end
  end

  // ----------------------------------------
  // Step interval
  // ----------------------------------------
  // step interval from duration
  // Wide divide traded for no lookup table
  assign prod = {`LSF_PROD_PAD, tenths} * TENTH_CYCLES;
  always @* begin
    limit = prod[31:0] / `LSF_STEPS;
  end
  // Very short fades give limit zero: a step each cycle
  assign step_due = (tick + `LSF_TICK_ONE) >= limit;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always @* begin
    next_tick = tick + `LSF_TICK_ONE;
    next_applied = applied;
    if (at_goal) begin
      next_tick = `LSF_TICK_ZERO;
    end else if (code == `LSF_FADE_OFF) begin
      next_applied = goal;
      next_tick = `LSF_TICK_ZERO;
    end else if (step_due) begin
      next_tick = `LSF_TICK_ZERO;
      if (going_up) begin
        next_applied = applied + `LSF_CODE_STEP;
      end else begin
        next_applied = applied - `LSF_CODE_STEP;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (!resetn) begin
      applied <= `LSF_CODE_ZERO;
      tick <= `LSF_TICK_ZERO;
    end else begin
      applied <= next_applied;
      tick <= next_tick;
    end
  end
endmodule // lsf_ramp

// What this block does
// - Fade codes in bits 7:4, 3:0; zero disables
// - Codes one to ten give 0.3 s steps
// - Codes eleven to fifteen add half seconds
// - Fade-out duration is full scale to zero
// - Fade-in duration is zero to full scale
// - Seven-bit current code per LED, bit 7 reserved
// - Code drives nonlinear DAC, ones is 30 mA
// - Off and on transitions are faded
module lsf_sink_fade #(
  parameter TENTH_CYCLES = 1000000
) (
  ref_clk,
  resetn,
  reg_addr,
  reg_wdata,
  reg_we,
  reg_rdata,
  led1_on,
  led2_on,
  led1_dac_code,
  led2_dac_code
);
  input wire ref_clk;
  input wire resetn;
  input wire [7:0] reg_addr;
  input wire [7:0] reg_wdata;
  input wire reg_we;
  output reg [7:0] reg_rdata;
  input wire led1_on;
  input wire led2_on;
  output wire [6:0] led1_dac_code;
  output wire [6:0] led2_dac_code;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [3:0] fade_down_code;
  reg [3:0] fade_up_code;
  reg [6:0] led1_current_code;
  reg [6:0] led2_current_code;

  always @(posedge ref_clk) begin
    if (!resetn) begin
      fade_down_code <= `LSF_FADE_OFF;
      fade_up_code <= `LSF_FADE_OFF;
      led1_current_code <= `LSF_CUR_RESET;
      led2_current_code <= `LSF_CUR_RESET;
    end else if (reg_we) begin
      case (reg_addr)
        `LSF_ADDR_FADE: begin
          fade_down_code <= reg_wdata[`LSF_FADE_DN_HI:`LSF_FADE_DN_LO];
          fade_up_code <= reg_wdata[`LSF_FADE_UP_HI:`LSF_FADE_UP_LO];
        end
        // reserved bit dropped
        // Bit 7 is never stored, so it cannot read back
        `LSF_ADDR_LED1: led1_current_code <= reg_wdata[`LSF_CUR_HI:`LSF_CUR_LO];
        `LSF_ADDR_LED2: led2_current_code <= reg_wdata[`LSF_CUR_HI:`LSF_CUR_LO];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Combinational so a read needs no wait state
  always @* begin
    case (reg_addr)
      `LSF_ADDR_FADE: reg_rdata = {fade_down_code, fade_up_code};
      `LSF_ADDR_LED1: reg_rdata = {`LSF_RSVD_ZERO, led1_current_code};
      `LSF_ADDR_LED2: reg_rdata = {`LSF_RSVD_ZERO, led2_current_code};
      default: reg_rdata = `LSF_READ_IDLE;
    endcase
  end

  // ----------------------------------------
  // Ramps
  // ----------------------------------------
  // Both channels share one fade register
  // on and off transitions fade
  lsf_ramp #(.TENTH_CYCLES(TENTH_CYCLES)) u_led1 (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .target(led1_current_code),
    .on_req(led1_on),
    .dn_code(fade_down_code),
    .up_code(fade_up_code),
    .applied(led1_dac_code)
  );

  lsf_ramp #(.TENTH_CYCLES(TENTH_CYCLES)) u_led2 (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .target(led2_current_code),
    .on_req(led2_on),
    .dn_code(fade_down_code),
    .up_code(fade_up_code),
    .applied(led2_dac_code)
  );
endmodule // lsf_sink_fade

/* File: tb/lsf_sink_fade_sva.sv */
// Port checker for the sink fade block
// --
// Checker
// --
module lsf_sink_fade_sva #(
  parameter TENTH_CYCLES = 1000000
) (
  input wire ref_clk,
  input wire resetn,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_we,
  input wire [7:0] reg_rdata,
  input wire led1_on,
  input wire led2_on,
  input wire [6:0] led1_dac_code,
  input wire [6:0] led2_dac_code
);
  reg [7:0] fd;
  wire [6:0] c = led1_dac_code;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Shadow of fade codes, so steps are judged by the code in force
  always @(posedge ref_clk) if (!resetn) fd <= 8'h00; else if (reg_we && reg_addr == 8'h1E) fd <= reg_wdata;
  a_rsvd_bit: assert property (reg_addr == 8'h1F |-> !reg_rdata[7]) else $error("bit 7 set");
  a_unmapped_read: assert property (reg_addr > 8'h20 |-> reg_rdata == 8'h00) else $error("unmapped");
  a_led1_write: assert property (reg_we && reg_addr == 8'h1F ##1 reg_addr == 8'h1F
    |-> reg_rdata == {1'b0, $past(reg_wdata[6:0])}) else $error("led1 write");
  a_led2_write: assert property (reg_we && reg_addr == 8'h20 ##1 reg_addr == 8'h20
    |-> reg_rdata == {1'b0, $past(reg_wdata[6:0])}) else $error("led2 write");
  a_fade_write: assert property (reg_we && reg_addr == 8'h1E ##1 reg_addr == 8'h1E
    |-> reg_rdata == $past(reg_wdata)) else $error("fade write");
  a_rise_needs_on: assert property (c > $past(c) |-> $past(led1_on) || $past(led1_on, 2))
    else $error("rise while off");
  a_up_one_step: assert property (c > $past(c) && $past(fd[3:0]) != 4'h0 |-> c == $past(c) + 7'h01)
    else $error("up step");
  a_dn_one_step: assert property (c < $past(c) && $past(fd[7:4]) != 4'h0 |-> c == $past(c) - 7'h01)
    else $error("down step");
endmodule // lsf_sink_fade_sva
bind lsf_sink_fade lsf_sink_fade_sva #(.TENTH_CYCLES(TENTH_CYCLES)) i_lsf_sink_fade_sva (.ref_clk, .resetn,
  .reg_addr, .reg_wdata, .reg_we, .reg_rdata, .led1_on, .led2_on, .led1_dac_code, .led2_dac_code);

/* File: tb/lsf_sink_fade_tb.sv */
// Register and fade ramp tests for the sink fade block
// --
// Bench
// --
module lsf_sink_fade_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, resetn = 0, reg_we = 0, led1_on = 0, led2_on = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  wire [7:0] reg_rdata;
  wire [6:0] led1_dac_code, led2_dac_code;
  int bad_count = 0, comparisons = 0, cyc = 0, n;
  // Short tenth keeps ramps to hundreds of cycles
  lsf_sink_fade #(.TENTH_CYCLES(10)) i_lsf_sink_fade (.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_we,
    .reg_rdata, .led1_on, .led2_on, .led1_dac_code, .led2_dac_code);
  initial forever #50 ref_clk = ~ref_clk;
  task stop_test;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string s, input logic [7:0] e, g);
    comparisons++;
    if (g !== e) begin bad_count++; $display("[FAIL] %s exp %h got %h", s, e, g); end
  endtask
  task wr(input logic [7:0] a, d);
    @(negedge ref_clk); reg_addr = a; reg_wdata = d; reg_we = 1;
    @(negedge ref_clk); reg_we = 0;
  endtask
  task rd(input logic [7:0] a, e);
    @(negedge ref_clk); reg_addr = a; #1 chk("rdata", e, reg_rdata);
  endtask
  // Cycles to reach a code; up to two step-timer periods of slack either side of the expected count
  task meas(input logic [6:0] e, input int lo, hi);
    n = 0;
    while (led1_dac_code !== e && n < 900) begin @(negedge ref_clk); n++; end
    comparisons++;
    if (n < lo || n > hi) begin bad_count++; $display("[FAIL] ramp exp %0d got %0d", lo, n); end
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin bad_count++; stop_test; end
  end
  initial begin
    repeat (6) @(negedge ref_clk);
    resetn = 1;
    rd(8'h1E, 8'h00);
    rd(8'h1F, 8'h00);
    wr(8'h1F, 8'hFF);
    wr(8'h20, 8'h55);
    wr(8'h21, 8'h3C);
    wr(8'h1E, 8'hA5);
    rd(8'h1F, 8'h7F);
    rd(8'h20, 8'h55);
    rd(8'h21, 8'h00);
    rd(8'h1E, 8'hA5);
    $display("test registers done");
    wr(8'h1E, 8'h00);
    led1_on = 1;
    led2_on = 1;
    repeat (2) @(negedge ref_clk);
    chk("led1 code", 8'h7F, {1'b0, led1_dac_code});
    chk("led2 code", 8'h55, {1'b0, led2_dac_code});
    wr(8'h1E, 8'hFA);
    led1_on = 0;
    meas(7'h00, 500, 516);
    led1_on = 1;
    meas(7'h7F, 250, 258);
    wr(8'h1F, 8'h3F);
    meas(7'h3F, 248, 260);
    $display("test fades done");
    stop_test;
  end
endmodule // lsf_sink_fade_tb
